// ---- logic/drwm_mapper.sv ----
// device end: block-select register and read-only window decode
// assumes a synchronous program memory read port with one cycle latency
// assumes the core end pulses each bus strobe for one cycle only
`include "drwm_regs.svh"
`default_nettype none
module drwm_mapper
  import drwm_pkg::*;
#(
  parameter int PADDR_W = 12,
  parameter int OFS_W = `DRWM_OFS_BITS,
  parameter int DATA_W = 8
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // core data-space side
  drwm_if.mapper bus,
  // program memory read port
  output logic [PADDR_W-1:0] pmem_addr_o,
  output logic pmem_re_o,
  input wire logic [DATA_W-1:0] pmem_rdata_i
);

  // window read timing, counted in edges from the one that takes it:
  // edge 0 takes the read, edge 1 pulses the memory, edge 2 sees the
  // byte stand on the memory port, edge 3 hands it to the core
  // a read before the first select write returns an undefined byte

  // ************************************************************
  // sizes
  // ************************************************************
  // a 2K program memory runs with PADDR_W of 11 and ignores select bit 5
  localparam int BLK_W = PADDR_W - OFS_W;
  localparam int SEL_BITS = `DRWM_BLK_MSB + 1;
  localparam int WIN_SPAN = `DRWM_WIN_LAST - `DRWM_WIN_BASE + 1;
  localparam int MEM_LAT = `DRWM_READ_LAT;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (DATA_W != 8) begin : g_bad_data
    $error("drwm_mapper: data width must be 8 to match the core bus");
  end

  if ((1 << OFS_W) != WIN_SPAN) begin : g_bad_ofs
    $error("drwm_mapper: offset width must cover the window exactly");
  end

  if (BLK_W < 1 || BLK_W > SEL_BITS) begin : g_bad_blk
    $error("drwm_mapper: block field must fit the select register");
  end

  // the answer stage below is one flop deep behind the memory
  if (MEM_LAT != 1) begin : g_bad_lat
    $error("drwm_mapper: only a one-cycle program memory is served");
  end

  // a select address inside the window would shadow a table byte
  if (`DRWM_SEL_ADDR >= `DRWM_WIN_BASE && `DRWM_SEL_ADDR <= `DRWM_WIN_LAST) begin : g_bad_sel
    $error("drwm_mapper: select register must lie outside the window");
  end

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic in_window(input drwm_daddr_t a);
    return (a >= `DRWM_WIN_BASE) && (a <= `DRWM_WIN_LAST);
  endfunction

  function automatic logic addr_is(input drwm_daddr_t a, input drwm_daddr_t target);
    return a == target;
  endfunction

  function automatic logic [BLK_W-1:0] blk_field(input drwm_data_t sel);
    return sel[BLK_W-1:0];
  endfunction

  function automatic logic [OFS_W-1:0] win_offset(input drwm_daddr_t a);
    return a[OFS_W-1:0];
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  // reserved select bits are stored as written but never used
  logic [7:0] blk_sel_reg;
  logic [7:0] blk_sel_next;

  // request to the program memory
  logic [PADDR_W-1:0] pmem_addr_next;
  logic pmem_re_next;

  // answer to the core
  logic rd_pend_reg;
  logic rd_pend_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic hit_reg;
  logic hit_next;

  // ************************************************************
  // decode
  // ************************************************************
  wire win_hit = in_window(bus.d_addr);
  wire sel_hit = addr_is(bus.d_addr, `DRWM_SEL_ADDR);
  wire sel_wr = bus.d_we && sel_hit;
  wire win_rd = bus.d_re && win_hit;

  // ************************************************************
  // program address
  // ************************************************************
  wire [BLK_W-1:0] blk_code = blk_field(blk_sel_reg);
  wire [OFS_W-1:0] win_ofs = win_offset(bus.d_addr);
  // block code above the offset: 64-byte steps over the whole memory
  wire [PADDR_W-1:0] paddr = {blk_code, win_ofs};

  // ************************************************************
  // next values
  // ************************************************************
  assign blk_sel_next = sel_wr ? bus.d_wdata : blk_sel_reg;
  // held between reads, so the select reaches the pins only through a window read
  assign pmem_addr_next = win_rd ? paddr : pmem_addr_o;
  assign pmem_re_next = win_rd;
  // the memory byte stands one cycle after the read pulse
  assign rd_pend_next = pmem_re_o;
  assign rdata_next = rd_pend_reg ? pmem_rdata_i : {DATA_W{1'b0}};
  assign rvalid_next = rd_pend_reg;
  assign hit_next = rd_pend_reg;

  // ************************************************************
  // select register: no reset on purpose, software writes it first
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    blk_sel_reg <= blk_sel_next;
  end

  // ************************************************************
  // program memory request
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pmem_addr_o <= {PADDR_W{1'b0}};
    end else begin
      pmem_addr_o <= pmem_addr_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pmem_re_o <= 1'b0;
    end else begin
      pmem_re_o <= pmem_re_next;
    end
  end

  // ************************************************************
  // memory answer wait
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_pend_reg <= 1'b0;
    end else begin
      rd_pend_reg <= rd_pend_next;
    end
  end

  // ************************************************************
  // answer to the core
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= {DATA_W{1'b0}};
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= rvalid_next;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hit_reg <= 1'b0;
    end else begin
      hit_reg <= hit_next;
    end
  end

  // ************************************************************
  // bus drive
  // ************************************************************
  assign bus.d_rdata = rdata_reg;
  assign bus.d_rvalid = rvalid_reg;
  assign bus.d_hit = hit_reg;
endmodule // drwm_mapper
`default_nettype wire

// ---- shared/drwm_regs.svh ----
// constants of the data rom window mapper: data-space map, field layout
// assumes an 8-bit data space and a 12-bit program memory address
//
// Function
// - window 0040h..007Fh returns selected program byte
// - window reaches every program address 0000h..0FFFh
// - program memory is 64 blocks of 64
// - program address is block code above offset
// - select low six bits used, top two reserved
// - select undefined after reset, write first
// - software never reads or modifies select register
// - load select, then offset, then read window
// - keep ram image before writing in interrupts
// - select register at 0C9h, written like ram
`ifndef DRWM_REGS_SVH
`define DRWM_REGS_SVH
`define DRWM_WIN_BASE 8'h40
`define DRWM_WIN_LAST 8'h7F
`define DRWM_SEL_ADDR 8'hC9
`define DRWM_BLK_MSB 5
`define DRWM_OFS_BITS 6
`define DRWM_READ_LAT 1
`endif

// ---- shared/drwm_pkg.sv ----
// types shared by both ends of the data rom window mapper
// assumes drwm_regs.svh is on the include path
`default_nettype none
package drwm_pkg;
  typedef logic [7:0] drwm_data_t;
  typedef logic [7:0] drwm_daddr_t;
  typedef logic [11:0] drwm_paddr_t;
  typedef enum logic [1:0] {DRWM_IDLE, DRWM_WRSEL, DRWM_RDWIN} drwm_op_t;
endpackage
`default_nettype wire

// ---- shared/drwm_if.sv ----
// interface joining the core-side bus master and the window mapper
// assumes one clock shared by both ends
`default_nettype none
interface drwm_if;
  logic [7:0] d_addr;
  logic [7:0] d_wdata;
  logic d_we;
  logic d_re;
  logic [7:0] d_rdata;
  logic d_rvalid;
  logic d_hit;
  modport mapper (
    input d_addr, d_wdata, d_we, d_re,
    output d_rdata, d_rvalid, d_hit
  );
  modport core (
    output d_addr, d_wdata, d_we, d_re,
    input d_rdata, d_rvalid, d_hit
  );
endinterface
`default_nettype wire

// ---- logic/drwm_core.sv ----
// core end: turns a user fetch request into select write then window read
// assumes the mapper answers a window read three cycles after the request
`include "drwm_regs.svh"
`default_nettype none
module drwm_core
  import drwm_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  drwm_if.core bus,
  input wire logic req_i,
  input wire logic [11:0] paddr_i,
  output logic busy_o,
  output logic done_o,
  output logic [7:0] data_o
);
  // ************************************************************
  // sequencer: select first, then offset read
  // ************************************************************
  typedef enum logic [1:0] {ST_IDLE, ST_SEL, ST_RD, ST_WAIT} drwm_st_t;
  drwm_st_t st_reg;
  logic [11:0] addr_reg;
  logic [7:0] a_reg;
  logic [7:0] wd_reg;
  logic we_reg;
  logic re_reg;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_reg <= ST_IDLE;
      addr_reg <= 12'h000;
      a_reg <= 8'h00;
      wd_reg <= 8'h00;
      we_reg <= 1'b0;
      re_reg <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      we_reg <= 1'b0;
      re_reg <= 1'b0;
      done_o <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          if (req_i) begin
            addr_reg <= paddr_i;
            busy_o <= 1'b1;
            st_reg <= ST_SEL;
          end
        end
        ST_SEL: begin
          // plain write only, reserved bits zero; never read back
          a_reg <= `DRWM_SEL_ADDR;
          wd_reg <= {2'b00, addr_reg[11:6]};
          we_reg <= 1'b1;
          st_reg <= ST_RD;
        end
        ST_RD: begin
          a_reg <= `DRWM_WIN_BASE | {2'b00, addr_reg[5:0]};
          re_reg <= 1'b1;
          st_reg <= ST_WAIT;
        end
        ST_WAIT: begin
          if (bus.d_rvalid) begin
            data_o <= bus.d_rdata;
            done_o <= 1'b1;
            busy_o <= 1'b0;
            st_reg <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end
  // no interrupt context here, so no ram image is kept
  assign bus.d_addr = a_reg;
  assign bus.d_wdata = wd_reg;
  assign bus.d_we = we_reg;
  assign bus.d_re = re_reg;
endmodule // drwm_core
`default_nettype wire

// ---- dv/drwm_assertions.sv ----
// checker on the bus between core end and mapper end
// assumes the bench memory holds a[11:4]^a[7:0] at address a
`include "drwm_regs.svh"
`default_nettype none
module drwm_assertions (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] d_addr,
  input wire logic [7:0] d_wdata,
  input wire logic d_we,
  input wire logic d_re,
  input wire logic [7:0] d_rdata,
  input wire logic d_rvalid,
  input wire logic d_hit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sel_reg;
  logic seen_reg;
  logic [5:0] ofs_d1_reg;
  logic [5:0] ofs_d2_reg;
  logic [5:0] ofs_d3_reg;
  wire logic sel_wr = d_we && d_addr == `DRWM_SEL_ADDR;
  wire logic in_win = d_addr >= `DRWM_WIN_BASE && d_addr <= `DRWM_WIN_LAST;
  // offset of the read answered now, taken three edges back
  wire logic [11:0] pa = {sel_reg[5:0], ofs_d3_reg};
  // select is never reset, so only its written value is trusted
  always_ff @(posedge sys_clk_i) begin
    if (sel_wr) sel_reg <= d_wdata;
    seen_reg <= rst_i ? 1'b0 : (seen_reg | sel_wr);
    ofs_d1_reg <= d_addr[5:0];
    ofs_d2_reg <= ofs_d1_reg;
    ofs_d3_reg <= ofs_d2_reg;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  property p_win_ans; d_re && in_win |-> ##3 d_rvalid; endproperty
  a_win_ans: assert property (p_win_ans) else $error("window read unanswered");
  property p_no_spur; d_rvalid |-> $past(d_re, 3); endproperty
  a_no_spur: assert property (p_no_spur) else $error("answer without read");
  property p_data; d_rvalid |-> d_rdata == (pa[11:4] ^ pa[7:0]); endproperty
  a_data: assert property (p_data) else $error("wrong window byte");
  property p_hit; d_rvalid || d_hit |-> d_rvalid && d_hit; endproperty
  a_hit: assert property (p_hit) else $error("hit and valid differ");
  property p_pulse; d_rvalid |=> !d_rvalid; endproperty
  a_pulse: assert property (p_pulse) else $error("answer held too long");
  property p_sel_first; d_re |-> seen_reg; endproperty
  a_sel_first: assert property (p_sel_first) else $error("read before select");
  property p_we; d_we |-> sel_wr ##1 (d_re && in_win); endproperty
  a_we: assert property (p_we) else $error("select write not followed");
  property p_we_one; d_we |=> !d_we; endproperty
  a_we_one: assert property (p_we_one) else $error("write strobe held");
  property p_no_sel_rd; d_re |-> d_addr != `DRWM_SEL_ADDR; endproperty
  a_no_sel_rd: assert property (p_no_sel_rd) else $error("select register read");
endmodule // drwm_assertions
`default_nettype wire

// ---- dv/tb.sv ----
// bench: core end fetches through the mapper end
// assumes a one-cycle program memory model here
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [11:0] pm_addr;
  logic pm_re;
  logic [7:0] pm_data = 8'h00;
  logic busy;
  logic done;
  logic [7:0] data;
  int miscompares = 0;
  int checks_done = 0;
  logic [11:0] addrs [6] = '{12'h000, 12'h03F, 12'h040, 12'hA95, 12'hFC0, 12'hFFF};
  drwm_if bus_if ();
  always #10 sys_clk_i = ~sys_clk_i;
  // idle memory output flips so a stale byte cannot match
  always_ff @(posedge sys_clk_i) pm_data <= pm_re ? pm_addr[11:4] ^ pm_addr[7:0] : ~pm_data;
  drwm_mapper drwm_mapper_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus_if),
    .pmem_addr_o(pm_addr), .pmem_re_o(pm_re), .pmem_rdata_i(pm_data));
  drwm_core drwm_core_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .bus(bus_if), .req_i(req),
    .paddr_i(paddr), .busy_o(busy), .done_o(done), .data_o(data));
  drwm_assertions drwm_assertions_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .d_addr(bus_if.d_addr), .d_wdata(bus_if.d_wdata), .d_we(bus_if.d_we), .d_re(bus_if.d_re),
    .d_rdata(bus_if.d_rdata), .d_rvalid(bus_if.d_rvalid), .d_hit(bus_if.d_hit));
  task automatic finish_test();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic fetch(input logic [11:0] a);
    int n;
    @(posedge sys_clk_i) #1;
    req = 1'b1;
    paddr = a;
    @(posedge sys_clk_i) #1;
    req = 1'b0;
    check("busy_o", 8'h01, {7'h00, busy});
    n = 0;
    while (done !== 1'b1) begin
      @(posedge sys_clk_i) #1;
      n++;
      if (n > 20) begin
        miscompares++;
        finish_test();
      end
    end
    check("data_o", a[11:4] ^ a[7:0], data);
    @(posedge sys_clk_i) #1;
    check("busy_o", 8'h00, {7'h00, busy});
    check("done_o", 8'h00, {7'h00, done});
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    foreach (addrs[i]) fetch(addrs[i]);
    $display("test block edges done");
    @(posedge sys_clk_i) #1 rst_i = 1'b1;
    @(posedge sys_clk_i) #1 rst_i = 1'b0;
    fetch(12'h7C1);
    $display("test fetch after reset done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
